// [core/cdu_pkg.sv]
// constants, types and shared functions of the config download/update ctrl
// assumes: single 40 MHz clock, registers reached over a 32-bit APB slave
// Notes on behaviour
// - margining code applied as written inside limits, else clipped to limit
// - margining output disabled whenever lower limit exceeds upper limit
// - limit values are part of the configuration restored at startup
// - every config value held in first stage, copied to driving second stage
// - power-up download starts once supply is above lockout level
// - download fills all first stages, then one common transfer to second
// - first engine state loaded a fixed delay after download completes
// - bus accesses before download completion are refused
// - transparent bit set: bus writes reach both stages at once
// - transparent bit clear: bus writes reach first stage only
// - host writes transfer bit; one pulse copies all first to second
// - nonvolatile writes leave RAM alone until a download is commanded
// - page erase done only while erase enable set, otherwise ignored
// - engine states: dedicated nonvolatile area, 64 words, last slot reserved
// - conditions met: next state word fetched taking about the load time
// - no RAM copy of states; host rewrites state words in nonvolatile area
// - host sets address pointer first; it selects the byte accessed next
// - erase enable is bit 2 of update config; erase has its command code
// - bit 0 of user download register starts a configuration download
package cdu_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_PTR   = 8'h00;
  localparam logic [7:0] ADDR_DATA  = 8'h04;
  localparam logic [7:0] ADDR_UPD   = 8'h08;
  localparam logic [7:0] ADDR_UDL   = 8'h0C;
  localparam logic [7:0] ADDR_NADR  = 8'h10;
  localparam logic [7:0] ADDR_NDAT  = 8'h14;
  localparam logic [7:0] ADDR_NCMD  = 8'h18;
  localparam logic [7:0] ADDR_STAT  = 8'h1C;
  // ==========================================================
  // field positions
  localparam int UPD_TRANSP   = 0;
  localparam int UPD_XFER     = 1;
  localparam int UPD_ERASE_EN = 2;
  localparam int UDL_START    = 0;
  localparam logic [7:0] CMD_ERASE = 8'hFE;
  // ==========================================================
  // configuration layout
  localparam int CFG_N      = 16;
  localparam int DAC_N      = 4;
  localparam logic [3:0] DAC_BASE = 4'h0;
  localparam logic [3:0] UPL_BASE = 4'h4;
  localparam logic [3:0] LOL_BASE = 4'h8;
  localparam logic [3:0] CFG_LAST = 4'hF;
  localparam logic [10:0] NVM_CFG_BASE = 11'h000;
  localparam logic [10:0] NVM_SE_BASE  = 11'h200;
  localparam logic [5:0]  SE_LAST      = 6'h3E;
  localparam logic [2:0]  SE_BYTE_LAST = 3'h7;
  // ==========================================================
  // nonvolatile operations
  typedef enum logic [1:0] {NVM_NOP, NVM_READ, NVM_WRITE, NVM_ERASE}
    cdu_nvm_op_t;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SE_DELAY_NS    = 500000;
  localparam int SE_LOAD_NS     = 10000;
  localparam int SE_DELAY_CYC   = SE_DELAY_NS / CLK_PERIOD_NS;
  localparam int SE_LOAD_CYC    = SE_LOAD_NS / CLK_PERIOD_NS;
  localparam int TMR_W          = 16;

  // clip a code into [lo, hi]
  function automatic logic [7:0] cdu_clip(input logic [7:0] code,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (code < lo) begin
      return lo;
    end else if (code > hi) begin
      return hi;
    end
    return code;
  endfunction
endpackage

// [core/cdu_timer.sv]
// down counter for the engine delays
// assumes: start is a one-cycle pulse, load is held for that cycle
module cdu_timer (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     start,
  input  wire logic [cdu_pkg::TMR_W-1:0] load,
  output logic                          expired
);
  logic [cdu_pkg::TMR_W-1:0] cnt_r;

  // ==========================================================
  // counter
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= load;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign expired = (cnt_r == '0);
endmodule

// [core/cdu_clip.sv]
// margining code clipping and output enables for all channels
// assumes: inputs are second-stage values, result registered by caller
module cdu_clip (
  input  wire logic [8*cdu_pkg::DAC_N-1:0] code,
  input  wire logic [8*cdu_pkg::DAC_N-1:0] upper,
  input  wire logic [8*cdu_pkg::DAC_N-1:0] lower,
  output logic      [8*cdu_pkg::DAC_N-1:0] clipped,
  output logic      [cdu_pkg::DAC_N-1:0]   oe
);
  // ==========================================================
  // per channel clip and enable
  always_comb begin
    for (int i = 0; i < cdu_pkg::DAC_N; i++) begin
      clipped[8*i +: 8] = cdu_pkg::cdu_clip(code[8*i +: 8],
                            lower[8*i +: 8], upper[8*i +: 8]);
      oe[i] = !(lower[8*i +: 8] > upper[8*i +: 8]);
    end
  end
endmodule

// [core/cdu_ctrl.sv]
// configuration download and update controller, APB slave top
// assumes: nonvolatile store answers each request with a one-cycle ack
//
// Chosen here: the placing of the registers and register access over APB.
module cdu_ctrl #(
  parameter int SE_DELAY = cdu_pkg::SE_DELAY_CYC
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          supply_ok,
  input  wire logic          seq_cond_met,
  output logic               nvm_req,
  output logic [1:0]         nvm_op,
  output logic [10:0]        nvm_addr,
  output logic [7:0]         nvm_wdata,
  input  wire logic          nvm_ack,
  input  wire logic [7:0]    nvm_rdata,
  output logic [127:0]       cfg_active,
  output logic               xfer_pulse,
  output logic [31:0]        dac_code,
  output logic [3:0]         dac_oe,
  output logic [63:0]        se_word,
  output logic               se_load,
  output logic               dl_busy
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DL_READ, ST_DL_XFER, ST_SE_WAIT, ST_SE_READ, ST_RUN,
    ST_NVM_OP
  } cdu_state_t;

  typedef struct packed {
    cdu_state_t      st;
    logic [7:0]      ptr;
    logic            transp;
    logic            erase_en;
    logic [15:0][7:0] la;
    logic [15:0][7:0] lb;
    logic [3:0]      idx;
    logic [5:0]      se_idx;
    logic [2:0]      se_byte;
    logic [63:0]     se_buf;
    logic [63:0]     se_out;
    logic            se_load;
    logic            pwrup_done;
    logic            xfer;
    logic            nvm_req;
    logic [1:0]      nvm_op;
    logic [10:0]     nvm_addr;
    logic [7:0]      nvm_wdata;
    logic [10:0]     host_addr;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
    logic [31:0]     dac_out;
    logic [3:0]      dac_oe;
    logic            busy;
  } cdu_regs_t;

  cdu_regs_t                  s_r;
  cdu_regs_t                  s_nxt;
  logic                       tmr_start;
  logic [cdu_pkg::TMR_W-1:0]  tmr_load;
  logic                       tmr_expired;
  logic [31:0]                clip_code;
  logic [31:0]                clip_upper;
  logic [31:0]                clip_lower;
  logic [31:0]                clipped;
  logic [3:0]                 clip_oe;
  logic                       wr_done;
  logic                       bus_ok;
  logic                       nvm_ok;

  // ==========================================================
  // helper functions
  function automatic logic [31:0] lane_group(input logic [15:0][7:0] l,
                                             input logic [3:0] base);
    logic [31:0] w;
    w = '0;
    for (int i = 0; i < cdu_pkg::DAC_N; i++) begin
      w[8*i +: 8] = l[base + 4'(i)];
    end
    return w;
  endfunction

  function automatic logic ptr_valid(input logic [7:0] p);
    return p < 8'(cdu_pkg::CFG_N);
  endfunction

  // ==========================================================
  // submodules
  cdu_timer u_timer (
    .mclk    (mclk),
    .reset   (reset),
    .start   (tmr_start),
    .load    (tmr_load),
    .expired (tmr_expired)
  );

  assign clip_code  = lane_group(s_r.lb, cdu_pkg::DAC_BASE);
  assign clip_upper = lane_group(s_r.lb, cdu_pkg::UPL_BASE);
  assign clip_lower = lane_group(s_r.lb, cdu_pkg::LOL_BASE);

  cdu_clip u_clip (
    .code    (clip_code),
    .upper   (clip_upper),
    .lower   (clip_lower),
    .clipped (clipped),
    .oe      (clip_oe)
  );

  // access allowed only after the configuration is in place
  assign bus_ok  = s_r.pwrup_done && (s_r.st != ST_DL_READ)
                   && (s_r.st != ST_DL_XFER);
  assign nvm_ok  = (s_r.st == ST_RUN);
  assign wr_done = psel && penable && s_r.pready && pwrite
                   && !s_r.pslverr;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt     = s_r;
    tmr_start = 1'b0;
    tmr_load  = '0;
    s_nxt.xfer    = 1'b0;
    s_nxt.se_load = 1'b0;
    // apb answer prepared in the setup cycle
    s_nxt.pready  = psel && !penable;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = '0;
    if (psel && !penable) begin
      if (!bus_ok) begin
        s_nxt.pslverr = 1'b1;
      end else if (paddr == cdu_pkg::ADDR_PTR) begin
        s_nxt.prdata = {24'h00_0000, s_r.ptr};
      end else if (paddr == cdu_pkg::ADDR_DATA) begin
        if (ptr_valid(s_r.ptr)) begin
          s_nxt.prdata = {24'h00_0000, s_r.la[s_r.ptr[3:0]]};
        end
      end else if (paddr == cdu_pkg::ADDR_UPD) begin
        s_nxt.prdata[cdu_pkg::UPD_TRANSP]   = s_r.transp;
        s_nxt.prdata[cdu_pkg::UPD_ERASE_EN] = s_r.erase_en;
      end else if (paddr == cdu_pkg::ADDR_UDL) begin
        s_nxt.pslverr = pwrite && !nvm_ok;
      end else if (paddr == cdu_pkg::ADDR_NADR) begin
        s_nxt.prdata = {21'h00_0000, s_r.host_addr};
      end else if (paddr == cdu_pkg::ADDR_NDAT
                   || paddr == cdu_pkg::ADDR_NCMD) begin
        s_nxt.pslverr = pwrite && !nvm_ok;
      end else if (paddr == cdu_pkg::ADDR_STAT) begin
        s_nxt.prdata = {22'h00_0000, s_r.se_idx, s_r.dac_oe};
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
    // register writes take effect at the completing edge
    if (wr_done) begin
      if (paddr == cdu_pkg::ADDR_PTR) begin
        s_nxt.ptr = pwdata[7:0];
      end else if (paddr == cdu_pkg::ADDR_DATA
                   && ptr_valid(s_r.ptr)) begin
        s_nxt.la[s_r.ptr[3:0]] = pwdata[7:0];
        if (s_r.transp) begin
          s_nxt.lb[s_r.ptr[3:0]] = pwdata[7:0];
        end
      end else if (paddr == cdu_pkg::ADDR_UPD) begin
        s_nxt.transp   = pwdata[cdu_pkg::UPD_TRANSP];
        s_nxt.erase_en = pwdata[cdu_pkg::UPD_ERASE_EN];
        s_nxt.xfer     = pwdata[cdu_pkg::UPD_XFER];
      end else if (paddr == cdu_pkg::ADDR_UDL
                   && pwdata[cdu_pkg::UDL_START]) begin
        s_nxt.st  = ST_DL_READ;
        s_nxt.idx = '0;
      end else if (paddr == cdu_pkg::ADDR_NADR) begin
        s_nxt.host_addr = pwdata[10:0];
      end else if (paddr == cdu_pkg::ADDR_NDAT) begin
        // byte goes to the store only, RAM untouched
        s_nxt.st        = ST_NVM_OP;
        s_nxt.nvm_req   = 1'b1;
        s_nxt.nvm_op    = cdu_pkg::NVM_WRITE;
        s_nxt.nvm_addr  = s_r.host_addr;
        s_nxt.nvm_wdata = pwdata[7:0];
      end else if (paddr == cdu_pkg::ADDR_NCMD
                   && pwdata[7:0] == cdu_pkg::CMD_ERASE
                   && s_r.erase_en) begin
        s_nxt.st       = ST_NVM_OP;
        s_nxt.nvm_req  = 1'b1;
        s_nxt.nvm_op   = cdu_pkg::NVM_ERASE;
        s_nxt.nvm_addr = s_r.host_addr;
      end
    end
    // first-to-second copy on transfer pulse
    if (s_r.xfer) begin
      s_nxt.lb = s_r.la;
    end
    // sequencing
    case (s_r.st)
      ST_IDLE: begin
        if (supply_ok) begin
          s_nxt.st  = ST_DL_READ;
          s_nxt.idx = '0;
        end
      end
      ST_DL_READ: begin
        if (!s_r.nvm_req) begin
          s_nxt.nvm_req  = 1'b1;
          s_nxt.nvm_op   = cdu_pkg::NVM_READ;
          s_nxt.nvm_addr = cdu_pkg::NVM_CFG_BASE + 11'(s_r.idx);
        end else if (nvm_ack) begin
          s_nxt.nvm_req    = 1'b0;
          s_nxt.nvm_op     = cdu_pkg::NVM_NOP;
          s_nxt.la[s_r.idx] = nvm_rdata;
          s_nxt.idx        = s_r.idx + 4'h1;
          if (s_r.idx == cdu_pkg::CFG_LAST) begin
            s_nxt.st = ST_DL_XFER;
          end
        end
      end
      ST_DL_XFER: begin
        s_nxt.xfer = 1'b1;
        if (!s_r.pwrup_done) begin
          s_nxt.pwrup_done = 1'b1;
          s_nxt.st         = ST_SE_WAIT;
          tmr_start        = 1'b1;
          tmr_load         = cdu_pkg::TMR_W'(SE_DELAY);
        end else begin
          s_nxt.st = ST_RUN;
        end
      end
      ST_SE_WAIT: begin
        if (tmr_expired) begin
          s_nxt.st      = ST_SE_READ;
          s_nxt.se_idx  = '0;
          s_nxt.se_byte = '0;
          tmr_start     = 1'b1;
          tmr_load      = cdu_pkg::TMR_W'(cdu_pkg::SE_LOAD_CYC);
        end
      end
      ST_SE_READ: begin
        if (s_r.se_byte == cdu_pkg::SE_BYTE_LAST && s_r.nvm_op
            == cdu_pkg::NVM_NOP && !s_r.nvm_req) begin
          // all bytes in, hold until the load time has run out
          if (tmr_expired) begin
            s_nxt.st      = ST_RUN;
            s_nxt.se_out  = s_r.se_buf;
            s_nxt.se_load = 1'b1;
          end
        end else if (!s_r.nvm_req) begin
          s_nxt.nvm_req  = 1'b1;
          s_nxt.nvm_op   = cdu_pkg::NVM_READ;
          s_nxt.nvm_addr = cdu_pkg::NVM_SE_BASE
                           + {2'b00, s_r.se_idx, s_r.se_byte};
        end else if (nvm_ack) begin
          s_nxt.nvm_req = 1'b0;
          s_nxt.se_buf[8*s_r.se_byte +: 8] = nvm_rdata;
          if (s_r.se_byte == cdu_pkg::SE_BYTE_LAST) begin
            s_nxt.nvm_op = cdu_pkg::NVM_NOP;
          end else begin
            s_nxt.se_byte = s_r.se_byte + 3'h1;
          end
        end
      end
      ST_RUN: begin
        // a store op requested by this cycle's bus write must survive
        if (seq_cond_met && !wr_done) begin
          // next state, reserved last slot skipped
          s_nxt.st      = ST_SE_READ;
          s_nxt.se_idx  = (s_r.se_idx == cdu_pkg::SE_LAST) ? 6'h00
                          : s_r.se_idx + 6'h01;
          s_nxt.se_byte = '0;
          tmr_start     = 1'b1;
          tmr_load      = cdu_pkg::TMR_W'(cdu_pkg::SE_LOAD_CYC);
        end
      end
      ST_NVM_OP: begin
        if (nvm_ack) begin
          s_nxt.nvm_req = 1'b0;
          s_nxt.nvm_op  = cdu_pkg::NVM_NOP;
          s_nxt.st      = ST_RUN;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    // margining outputs follow second stage
    s_nxt.dac_out = clipped;
    s_nxt.dac_oe  = clip_oe;
    // read outstanding, kept in a flop for the busy output
    s_nxt.busy    = s_nxt.nvm_req && s_nxt.nvm_op == cdu_pkg::NVM_READ;
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign pready     = s_r.pready;
  assign prdata     = s_r.prdata;
  assign pslverr    = s_r.pslverr;
  assign nvm_req    = s_r.nvm_req;
  assign nvm_op     = s_r.nvm_op;
  assign nvm_addr   = s_r.nvm_addr;
  assign nvm_wdata  = s_r.nvm_wdata;
  assign cfg_active = s_r.lb;
  assign xfer_pulse = s_r.xfer;
  assign dac_code   = s_r.dac_out;
  assign dac_oe     = s_r.dac_oe;
  assign se_word    = s_r.se_out;
  assign se_load    = s_r.se_load;
  assign dl_busy    = s_r.busy;

  // ==========================================================
  // assertions
  AST_CLIP: assert property (@(posedge mclk) disable iff (reset)
    dac_code[7:0] == cdu_pkg::cdu_clip($past(s_r.lb[0]),
                      $past(s_r.lb[8]), $past(s_r.lb[4])))
    else $error("clipped code wrong");
  AST_HIZ: assert property (@(posedge mclk) disable iff (reset)
    ($past(s_r.lb[8]) > $past(s_r.lb[4])) |-> !dac_oe[0])
    else $error("output enabled with crossed limits");
  AST_XFER_COPY: assert property (@(posedge mclk) disable iff (reset)
    s_r.xfer |=> s_r.lb == $past(s_r.la))
    else $error("transfer did not copy first stage");
  AST_XFER_ONE: assert property (@(posedge mclk) disable iff (reset)
    s_r.xfer && s_r.st == ST_RUN |=> !s_r.xfer)
    else $error("transfer pulse too long");
  AST_STAGED: assert property (@(posedge mclk) disable iff (reset)
    wr_done && paddr == cdu_pkg::ADDR_DATA && !s_r.transp && !s_r.xfer
    |=> $stable(s_r.lb))
    else $error("staged write changed operating config");
  AST_TRANSP: assert property (@(posedge mclk) disable iff (reset)
    wr_done && paddr == cdu_pkg::ADDR_DATA && s_r.transp && !s_r.xfer
    && ptr_valid(s_r.ptr) |=> s_r.lb[$past(s_r.ptr[3:0])]
    == $past(pwdata[7:0]))
    else $error("transparent write missed second stage");
  AST_NACK: assert property (@(posedge mclk) disable iff (reset)
    psel && !penable && !s_r.pwrup_done |=> pready && pslverr)
    else $error("access accepted before download");
  AST_ERASE: assert property (@(posedge mclk) disable iff (reset)
    $rose(s_r.nvm_req) && s_r.nvm_op == cdu_pkg::NVM_ERASE
    |-> $past(s_r.erase_en))
    else $error("erase without enable");
  AST_SE_DELAY: assert property (@(posedge mclk) disable iff (reset)
    s_r.st == ST_DL_XFER && !s_r.pwrup_done
    |=> s_r.st == ST_SE_WAIT [*8])
    else $error("engine load came too early");
  AST_START: assert property (@(posedge mclk) disable iff (reset)
    s_r.st == ST_IDLE && supply_ok |=> s_r.st == ST_DL_READ)
    else $error("download did not start");
  COV_XFER: cover property (@(posedge mclk) disable iff (reset)
    wr_done && paddr == cdu_pkg::ADDR_UPD && pwdata[cdu_pkg::UPD_XFER]
    ##1 s_r.xfer);
  COV_SE: cover property (@(posedge mclk) disable iff (reset) s_r.se_load);
  COV_ERASE: cover property (@(posedge mclk) disable iff (reset)
    s_r.nvm_req && s_r.nvm_op == cdu_pkg::NVM_ERASE);
endmodule

// [test/cdu_nvm_model.sv]
// nonvolatile store model facing the controller's store port
// assumes: req held until ack, ack one cycle, odd addresses answer slowly
module cdu_nvm_model #(
  parameter logic [127:0] CFG_INIT = '0
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        nvm_req,
  input  wire logic [1:0]  nvm_op,
  input  wire logic [10:0] nvm_addr,
  input  wire logic [7:0]  nvm_wdata,
  output logic             nvm_ack,
  output logic [7:0]       nvm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [2048];
  logic [1:0] cnt;
  logic [1:0] lat;
  // ==========================================================
  // contents: low address byte everywhere, config image at the base
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = i[7:0];
    end
    for (int i = 0; i < 16; i++) begin
      mem[i] = CFG_INIT[8*i +: 8];
    end
    nvm_ack = 1'b0;
    nvm_rdata = 8'h00;
    cnt = 2'h0;
  end
  assign lat = nvm_addr[0] ? 2'h3 : 2'h0;
  // ==========================================================
  // request service; data line toggles except when answering a read
  always @(posedge mclk) begin
    nvm_ack <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (reset) begin
      cnt <= 2'h0;
    end else if (nvm_req && !nvm_ack) begin
      if (cnt != lat) begin
        cnt <= cnt + 2'h1;
      end else begin
        cnt <= 2'h0;
        nvm_ack <= 1'b1;
        if (nvm_op == cdu_pkg::NVM_READ) begin
          nvm_rdata <= mem[nvm_addr];
        end else if (nvm_op == cdu_pkg::NVM_WRITE) begin
          mem[nvm_addr] <= nvm_wdata;
        end else if (nvm_op == cdu_pkg::NVM_ERASE) begin
          for (int j = 0; j < 32; j++) begin
            mem[{nvm_addr[10:5], j[4:0]}] <= 8'hFF;
          end
        end
      end
    end
  end
endmodule

// [test/testbench.sv]
// self-checking bench of the download/update controller
// assumes: cdu_pkg, cdu_ctrl and the store model compiled before
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] CFG = 128'h0000_0000_6020_2020_40C0_C0C0_80F0_1050;
  localparam int SE_DL = 20;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic supply_ok = 0, seq_cond_met = 0, pready, pslverr;
  logic nvm_req, nvm_ack, xfer_pulse, se_load, dl_busy;
  logic [7:0]   paddr = 8'h00, nvm_wdata, nvm_rdata;
  logic [31:0]  pwdata = 32'h0000_0000, prdata, dac_code;
  logic [1:0]   nvm_op;
  logic [10:0]  nvm_addr;
  logic [127:0] cfg_active;
  logic [3:0]   dac_oe;
  logic [63:0]  se_word;
  int fails = 0, n_compared = 0, n_xfer = 0, cyc = 0;
  cdu_ctrl #(.SE_DELAY(SE_DL)) cdu_ctrl_inst (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_ok(supply_ok), .seq_cond_met(seq_cond_met), .nvm_req(nvm_req),
    .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .cfg_active(cfg_active),
    .xfer_pulse(xfer_pulse), .dac_code(dac_code), .dac_oe(dac_oe),
    .se_word(se_word), .se_load(se_load), .dl_busy(dl_busy));
  cdu_nvm_model #(.CFG_INIT(CFG)) cdu_nvm_model_inst (.mclk(mclk),
    .reset(reset), .nvm_req(nvm_req), .nvm_op(nvm_op),
    .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack),
    .nvm_rdata(nvm_rdata));
  // ==========================================================
  // clock, transfer pulse count, hang guard
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (xfer_pulse === 1'b1) n_xfer <= n_xfer + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [127:0] seen, exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  // ==========================================================
  // bus master: setup, access held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // wait for the answer; only the global cycle guard ends a hang
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic wait_xfer();
    int n0;
    n0 = n_xfer;
    for (int i = 0; i < 3000 && n_xfer == n0; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic wait_se(output int n);
    for (n = 0; n < 3000 && se_load !== 1'b1; n++) @(posedge mclk);
  endtask
  task automatic wait_idle();
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 100 && nvm_req !== 1'b0; i++) @(posedge mclk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_powerup();
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b0, cdu_pkg::ADDR_STAT, 32'h0, r, e);
    check(e, 1'b1, "early access taken");
    supply_ok <= 1'b1;
    wait_xfer();
    check(cfg_active, CFG, "power-up image");
    check(dac_code, 32'h40C0_2050, "clipped codes");
    check(dac_oe, 4'h7, "inverted limits not disabled");
    wait_se(n);
    check(n + 4 > SE_DL + cdu_pkg::SE_LOAD_CYC, 1'b1, "load too early");
    check(se_word, 64'h0706_0504_0302_0100, "first state");
    apb(1'b0, 8'h20, 32'h0, r, e);
    check(e, 1'b1, "unmapped read accepted");
    apb(1'b0, cdu_pkg::ADDR_STAT, 32'h0, r, e);
    check(r[3:0], 4'h7, "status enables");
    check(dl_busy, 1'b0, "busy while idle");
    $display("done powerup");
  endtask
  task automatic t_staged();
    logic [31:0] r;
    logic e;
    int n0;
    wr(cdu_pkg::ADDR_PTR, 32'h0000_0000);
    wr(cdu_pkg::ADDR_DATA, 32'h0000_0030);
    apb(1'b0, cdu_pkg::ADDR_DATA, 32'h0, r, e);
    check(r, 32'h0000_0030, "first stage readback");
    check(cfg_active[7:0], 8'h50, "staged write went live");
    n0 = n_xfer;
    wr(cdu_pkg::ADDR_UPD, 32'h0000_0002);
    repeat (4) @(posedge mclk);
    check(n_xfer - n0, 1, "transfer pulse count");
    check(cfg_active[7:0], 8'h30, "commit");
    check(dac_code, 32'h40C0_2030, "committed code");
    apb(1'b0, cdu_pkg::ADDR_UPD, 32'h0, r, e);
    check(r[1], 1'b0, "transfer bit stuck");
    $display("done staged");
  endtask
  task automatic t_transp();
    wr(cdu_pkg::ADDR_UPD, 32'h0000_0001);
    wr(cdu_pkg::ADDR_PTR, 32'h0000_0001);
    wr(cdu_pkg::ADDR_DATA, 32'h0000_0005);
    @(posedge mclk);
    check(cfg_active[15:8], 8'h05, "transparent write");
    repeat (2) @(posedge mclk);
    check(dac_code[15:8], 8'h20, "clip to lower");
    $display("done transparent");
  endtask
  task automatic t_nvm();
    logic [31:0] r;
    logic e;
    wr(cdu_pkg::ADDR_NADR, 32'h0000_0001);
    wr(cdu_pkg::ADDR_NDAT, 32'h0000_0077);
    wait_idle();
    check(cfg_active[15:8], 8'h05, "store write hit RAM");
    wr(cdu_pkg::ADDR_NADR, 32'h0000_0020);
    wr(cdu_pkg::ADDR_NCMD, 32'h0000_00FE);
    wait_idle();
    check(cdu_nvm_model_inst.mem[32], 8'h20, "erase not enabled");
    wr(cdu_pkg::ADDR_UPD, 32'h0000_0004);
    wr(cdu_pkg::ADDR_NCMD, 32'h0000_00FE);
    wait_idle();
    check(cdu_nvm_model_inst.mem[63], 8'hFF, "page erase");
    wr(cdu_pkg::ADDR_UDL, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    check(dl_busy, 1'b1, "download not busy");
    apb(1'b0, cdu_pkg::ADDR_STAT, 32'h0, r, e);
    check(e, 1'b1, "access during download taken");
    wait_xfer();
    check(cfg_active[15:0], 16'h7750, "user download");
    $display("done nvm");
  endtask
  task automatic t_seq();
    int n;
    seq_cond_met <= 1'b1;
    @(posedge mclk);
    seq_cond_met <= 1'b0;
    wait_se(n);
    check(n >= cdu_pkg::SE_LOAD_CYC, 1'b1, "state load too fast");
    check(se_word, 64'h0F0E_0D0C_0B0A_0908, "next state");
    $display("done sequence");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_powerup();
    t_staged();
    t_transp();
    t_nvm();
    t_seq();
    give_verdict();
  end
endmodule
